// >>> rtl/s7s_serializer.sv
// Seven-to-one display serializer: pixel capture, 7x bit timing and five lanes.
//
// Contract
// - Five 7-bit parallel-load serial-out lanes timed by a 7x bit clock generator.
// - 28 input bits per pixel clock leave on four data lanes and one clock lane.
// - Every active pixel clock edge while shutdown is high captures input bits 0..27 for the next frame.
// - Edge select high captures on rising pixel clock edge, low on falling edge.
// - Shutdown low stops the bit clock and disables line drivers; high runs normally.
// - Shutdown low clears the data, period and lane registers to zero and parks the bit index at its last bit.
// - Input supply off makes every input, shutdown included, read as high.
`timescale 1ns/1ps

module s7s_serializer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pixel_clock_in,
    input wire logic i_capture_edge_select,
    input wire logic i_shutdown_clear_n,
    input wire logic i_input_stage_supply,
    input wire logic [s7s_pkg::DATA_BITS-1:0] i_pixel_data,
    output s7s_pkg::s7s_serial_type o_serial,
    output logic o_driver_en,
    output logic o_bit_tick,
    output logic o_frame_start
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    s7s_pkg::s7s_state_type state;
    s7s_pkg::s7s_state_type next_state;

    logic supply_ok;
    logic pclk;
    logic edge_sel;
    logic shdn_n;
    logic [s7s_pkg::DATA_BITS-1:0] data_in;
    logic rise;
    logic fall;
    logic capture;
    logic clear;
    logic [s7s_pkg::PERIOD_WIDTH-1:0] accum_sum;

    // ------------------------------------------------------------------
    // Synchronised input view
    // ------------------------------------------------------------------
    // Inputs are sampled by the fast clock, so the source must hold data for
    // at least one fast cycle after the active edge.
    always_comb begin
        supply_ok = state.supply_s2;
        pclk = supply_ok ? state.pclk_s2 : 1'b1;
        edge_sel = supply_ok ? state.edge_sel_s2 : 1'b1;
        shdn_n = supply_ok ? state.shdn_s2 : 1'b1;
        data_in = supply_ok ? state.data_s2 : '1;
        rise = pclk && !state.pclk_prev;
        fall = !pclk && state.pclk_prev;
        capture = edge_sel ? rise : fall;
        clear = !shdn_n;
        accum_sum = state.accum + s7s_pkg::RATIO_STEP;
    end

    // ------------------------------------------------------------------
    // Period measurement
    // ------------------------------------------------------------------
    // The measured period is held at the ceiling instead of wrapping to zero.
    // A zero period would stop the bit generator for good on a slow pixel clock,
    // so a very slow source gets late bits rather than none.
    logic [s7s_pkg::PERIOD_WIDTH-1:0] period_meas;

    always_comb begin
        if (state.count == s7s_pkg::PERIOD_MAX) begin
            period_meas = s7s_pkg::PERIOD_MAX;
        end else begin
            period_meas = state.count + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.pclk_s1 = i_pixel_clock_in;
        next_state.pclk_s2 = state.pclk_s1;
        next_state.edge_sel_s1 = i_capture_edge_select;
        next_state.edge_sel_s2 = state.edge_sel_s1;
        next_state.shdn_s1 = i_shutdown_clear_n;
        next_state.shdn_s2 = state.shdn_s1;
        next_state.supply_s1 = i_input_stage_supply;
        next_state.supply_s2 = state.supply_s1;
        next_state.data_s1 = i_pixel_data;
        next_state.data_s2 = state.data_s1;
        next_state.pclk_prev = pclk;
        next_state.frame_start = 1'b0;
        next_state.bit_tick = 1'b0;
        next_state.driver_en = shdn_n;
        if (clear) begin
            // The synchronisers keep running so that release is seen promptly.
            next_state.load_reg = s7s_pkg::DATA_RESET;
            next_state.load_pend = 1'b0;
            next_state.count = s7s_pkg::COUNT_RESET;
            next_state.period = s7s_pkg::COUNT_RESET;
            next_state.accum = s7s_pkg::COUNT_RESET;
            next_state.bit_index = s7s_pkg::LAST_BIT_INDEX;
            next_state.driver_en = 1'b0;
        end else begin
            if (state.count != s7s_pkg::PERIOD_MAX) begin
                next_state.count = state.count + 1'b1;
            end
            if (capture) begin
                next_state.load_reg = data_in;
                next_state.load_pend = 1'b1;
                next_state.period = period_meas;
                next_state.count = s7s_pkg::COUNT_RESET;
            end
            if (state.load_pend) begin
                // Frame start realigns the 7x generator to the pixel clock.
                // An edge captured in this same cycle keeps its request pending;
                // the set wins so that the later capture is not dropped.
                next_state.load_pend = capture;
                next_state.frame_start = 1'b1;
                next_state.accum = s7s_pkg::COUNT_RESET;
                next_state.bit_index = s7s_pkg::INDEX_RESET;
            end else if (state.bit_index != s7s_pkg::LAST_BIT_INDEX &&
                         state.period != s7s_pkg::COUNT_RESET) begin
                // Fractional accumulator: a tick every seventh of the measured pixel period, six per frame.
                if (accum_sum >= state.period) begin
                    next_state.accum = accum_sum - state.period;
                    next_state.bit_tick = 1'b1;
                    next_state.bit_index = state.bit_index + 1'b1;
                end else begin
                    next_state.accum = accum_sum;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            // The supply flag starts as present: starting as absent would force
            // every input high, fake a pixel edge and light the drivers briefly.
            state <= '0;
            state.bit_index <= s7s_pkg::LAST_BIT_INDEX;
            state.supply_s1 <= 1'b1;
            state.supply_s2 <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Shift lanes
    // ------------------------------------------------------------------
    logic [s7s_pkg::LANES-1:0] lane_serial;
    logic clock_serial;

    genvar lane;
    generate
        for (lane = 0; lane < s7s_pkg::LANES; lane++) begin : g_lane
            s7s_shift_lane #(
                .WIDTH(s7s_pkg::BITS_PER_LANE)
            ) u_lane (
                .i_clk(i_clk),
                .i_rst_n(rst_n),
                .i_clear(clear),
                .i_load(state.frame_start),
                .i_load_data(state.load_reg[lane*s7s_pkg::BITS_PER_LANE +:
                                            s7s_pkg::BITS_PER_LANE]),
                .i_shift(state.bit_tick),
                .o_serial(lane_serial[lane])
            );
        end
    endgenerate

    s7s_shift_lane #(
        .WIDTH(s7s_pkg::BITS_PER_LANE)
    ) u_clock_lane (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_clear(clear),
        .i_load(state.frame_start),
        .i_load_data(s7s_pkg::CLOCK_LANE_PATTERN),
        .i_shift(state.bit_tick),
        .o_serial(clock_serial)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Lines are quiet whenever the drivers are off, so a panel sees zeros.
    always_comb begin
        o_serial.data = state.driver_en ? lane_serial : '0;
        o_serial.clock = state.driver_en ? clock_serial : 1'b0;
    end

    assign o_driver_en = state.driver_en;
    assign o_bit_tick = state.bit_tick;
    assign o_frame_start = state.frame_start;

endmodule : s7s_serializer

// >>> rtl/s7s_pkg.sv
// Shared constants and state types for the seven-to-one display serializer.
package s7s_pkg;

    // ------------------------------------------------------------------
    // Link geometry
    // ------------------------------------------------------------------
    localparam int LANES = 4;
    localparam int BITS_PER_LANE = 7;
    localparam int DATA_BITS = LANES * BITS_PER_LANE;
    localparam int SERIAL_RATIO = 7;
    localparam logic [BITS_PER_LANE-1:0] CLOCK_LANE_PATTERN = 7'h63;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h6;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PERIOD_WIDTH = 12;
    localparam logic [PERIOD_WIDTH-1:0] PERIOD_MAX = 12'hFFF;
    localparam logic [PERIOD_WIDTH-1:0] RATIO_STEP = 12'h007;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_BITS-1:0] DATA_RESET = 28'h0000000;
    localparam logic [PERIOD_WIDTH-1:0] COUNT_RESET = 12'h000;
    localparam logic [2:0] INDEX_RESET = 3'h0;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pclk_s1;
        logic pclk_s2;
        logic pclk_prev;
        logic edge_sel_s1;
        logic edge_sel_s2;
        logic shdn_s1;
        logic shdn_s2;
        logic supply_s1;
        logic supply_s2;
        logic [DATA_BITS-1:0] data_s1;
        logic [DATA_BITS-1:0] data_s2;
        logic [DATA_BITS-1:0] load_reg;
        logic load_pend;
        logic frame_start;
        logic [PERIOD_WIDTH-1:0] count;
        logic [PERIOD_WIDTH-1:0] period;
        logic [PERIOD_WIDTH-1:0] accum;
        logic [2:0] bit_index;
        logic bit_tick;
        logic driver_en;
    } s7s_state_type;

    typedef struct packed {
        logic [LANES-1:0] data;
        logic clock;
    } s7s_serial_type;

endpackage : s7s_pkg

// >>> rtl/s7s_shift_lane.sv
// One parallel-load, serial-out shift register lane of the serializer.
`timescale 1ns/1ps

module s7s_shift_lane #(
    parameter int WIDTH = 7
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_data,
    input wire logic i_shift,
    output logic o_serial
);

    typedef struct packed {
        logic [WIDTH-1:0] shift;
        logic serial;
    } s7s_lane_state_type;

    s7s_lane_state_type state;
    s7s_lane_state_type next_state;

    // ------------------------------------------------------------------
    // Shift logic
    // ------------------------------------------------------------------
    // Lowest-index bit goes out first; load puts bit 0 on the line at once.
    always_comb begin
        next_state = state;
        if (i_clear) begin
            next_state = '0;
        end else if (i_load) begin
            next_state.serial = i_load_data[0];
            next_state.shift = {1'b0, i_load_data[WIDTH-1:1]};
        end else if (i_shift) begin
            next_state.serial = state.shift[0];
            next_state.shift = {1'b0, state.shift[WIDTH-1:1]};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_serial = state.serial;

endmodule : s7s_shift_lane

// >>> bench/s7s_serializer_checker.sv
// Port-level checks for the seven-to-one display serializer.
`timescale 1ns/1ps

module s7s_serializer_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_shutdown_clear_n,
    input wire logic i_input_stage_supply,
    input wire s7s_pkg::s7s_serial_type o_serial,
    input wire logic o_driver_en,
    input wire logic o_bit_tick,
    input wire logic o_frame_start
);
    // ------------------------------------------------------------------
    // Lane bit index
    // ------------------------------------------------------------------
    logic [2:0] bit_idx;

    // The index counts ticks since the last load, so it names the bit on show.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_idx <= 3'h0;
        end else if (o_frame_start) begin
            bit_idx <= 3'h0;
        end else if (o_bit_tick) begin
            bit_idx <= bit_idx + 3'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_DRV_OFF_QUIET: assert property (!o_driver_en |-> o_serial == 5'h00)
        else $error("lanes active with drivers off");
    AST_SHDN_CLEAR: assert property ((!i_shutdown_clear_n && i_input_stage_supply)[*5]
        |-> !o_driver_en && !o_bit_tick && !o_frame_start) else $error("shutdown did not clear");
    AST_RUN_ON: assert property (i_shutdown_clear_n[*8] |-> o_driver_en)
        else $error("drivers off while running");
    AST_SUPPLY_FORCE: assert property ((!i_input_stage_supply)[*8] |-> o_driver_en)
        else $error("supply off did not force drivers on");
    AST_FRAME_PULSE: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start longer than one cycle");
    AST_TICKS_FOLLOW: assert property (o_frame_start && i_shutdown_clear_n
        |-> ##[1:20] (o_bit_tick || !o_driver_en)) else $error("no bit tick after frame start");
    AST_TICK_LIMIT: assert property (o_bit_tick && !o_frame_start |-> bit_idx != 3'h6)
        else $error("more than seven bits in a frame");
    AST_CLOCK_LANE: assert property ($past(o_frame_start || o_bit_tick) && o_driver_en
        |-> o_serial.clock == s7s_pkg::CLOCK_LANE_PATTERN[bit_idx]) else $error("clock lane bit");
endmodule : s7s_serializer_checker

bind s7s_serializer s7s_serializer_checker u_s7s_serializer_checker (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_shutdown_clear_n(i_shutdown_clear_n),
    .i_input_stage_supply(i_input_stage_supply), .o_serial(o_serial),
    .o_driver_en(o_driver_en), .o_bit_tick(o_bit_tick), .o_frame_start(o_frame_start));

// >>> bench/s7s_pixel_source.sv
// Graphics source model: 80 ns pixel clock, words changing 30 ns after each edge.
`timescale 1ns/1ps

module s7s_pixel_source (
    input wire logic i_run,
    input wire logic [27:0] i_word_rise,
    input wire logic [27:0] i_word_fall,
    output logic o_pclk,
    output logic [27:0] o_data
);
    // Data holds 10 ns before and 30 ns after each edge, so each edge sees its own word.
    initial begin
        o_pclk = 1'b0;
        o_data = 28'h0000000;
        #3.3;
        forever begin
            if (i_run) begin
                o_pclk = 1'b1;
                #30 o_data = i_word_fall;
                #10 o_pclk = 1'b0;
                #30 o_data = i_word_rise;
                #10;
            end else begin
                // A stopped source no longer holds its last word.
                o_pclk = 1'b0;
                #40 o_data = ~o_data;
            end
        end
    end
endmodule : s7s_pixel_source

// >>> bench/test_s7s_serializer.sv
// Self-checking bench for the seven-to-one display serializer.
`timescale 1ns/1ps

module test_s7s_serializer;
    typedef struct packed {
        logic sel;
        logic [27:0] rise;
        logic [27:0] fall;
        logic [27:0] want;
    } s7s_row_type;
    s7s_row_type rows [4] = '{'{1'b1, 28'h8000001, 28'h7FFFFFE, 28'h8000001},
        '{1'b0, 28'h8000001, 28'h7FFFFFE, 28'h7FFFFFE},
        '{1'b1, 28'h5A3C96E, 28'h0000000, 28'h5A3C96E},
        '{1'b0, 28'hFFFFFFF, 28'h1234567, 28'h1234567}};
    logic i_clk = 1'b0, i_rst_n = 1'b0, sel = 1'b1, shdn_n = 1'b0, supply = 1'b1, run = 1'b0;
    logic [27:0] rise = 28'h0000000, fall = 28'h0000000, pdata, got, last_frame;
    logic pclk, drv_en, tick, fstart, shown = 1'b0;
    logic [6:0] pat, last_pat;
    s7s_pkg::s7s_serial_type ser;
    int idx = 0, frame_cnt = 0, n0 = 0, bad_count = 0, compares = 0;

    always #4 i_clk = ~i_clk;

    s7s_pixel_source u_s7s_pixel_source (.i_run(run), .i_word_rise(rise), .i_word_fall(fall),
        .o_pclk(pclk), .o_data(pdata));
    s7s_serializer u_s7s_serializer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pixel_clock_in(pclk),
        .i_capture_edge_select(sel), .i_shutdown_clear_n(shdn_n),
        .i_input_stage_supply(supply), .i_pixel_data(pdata), .o_serial(ser),
        .o_driver_en(drv_en), .o_bit_tick(tick), .o_frame_start(fstart));

    // ------------------------------------------------------------------
    // Lane monitor: rebuilds the 28-bit word and clock pattern of each frame
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (shown) begin
            for (int k = 0; k < 4; k++) got[7 * k + idx] = ser.data[k];
            pat[idx] = ser.clock;
            if (idx == 6) begin
                last_frame = got;
                last_pat = pat;
                frame_cnt++;
            end
        end
        shown = fstart || tick;
        idx = fstart ? 0 : (tick ? idx + 1 : idx);
    end

    task check(input logic [27:0] seen, input logic [27:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task tally_and_finish;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task wait_frames(input int n);
        int start;
        int guard;
        start = frame_cnt;
        guard = 0;
        while (frame_cnt < start + n && guard < 40 * n) begin
            step(1);
            guard++;
        end
        check(28'(frame_cnt >= start + n), 28'h0000001);
    endtask : wait_frames

    initial begin
        step(3);
        i_rst_n = 1'b1;
        run = 1'b1;
        step(20);
        shdn_n = 1'b1;
        wait_frames(4);
        check(last_frame, 28'h0000000);
        check(28'(drv_en), 28'h0000001);
        foreach (rows[r]) begin
            sel = rows[r].sel;
            rise = rows[r].rise;
            fall = rows[r].fall;
            wait_frames(3);
            check(last_frame, rows[r].want);
            check(28'(last_pat), 28'h0000063);
        end
        rise = 28'h0000000;
        fall = 28'h0000000;
        wait_frames(3);
        shdn_n = 1'b0;
        step(6);
        check(28'({drv_en, ser}), 28'h0000000);
        n0 = frame_cnt;
        step(26);
        run = 1'b0;
        check(28'(frame_cnt - n0), 28'h0000000);
        supply = 1'b0;
        step(10);
        check(28'(drv_en), 28'h0000001);
        supply = 1'b1;
        step(10);
        check(28'(drv_en), 28'h0000000);
        rise = 28'h2468ACE;
        fall = 28'h2468ACE;
        run = 1'b1;
        shdn_n = 1'b1;
        wait_frames(3);
        check(last_frame, 28'h2468ACE);
        i_rst_n = 1'b0;
        step(1);
        check(28'({drv_en, ser, tick, fstart}), 28'h0000000);
        i_rst_n = 1'b1;
        wait_frames(3);
        check(last_frame, 28'h2468ACE);
        tally_and_finish;
    end

    initial begin
        #100000;
        bad_count++;
        $display("wrong value at %0t: run did not finish", $time);
        tally_and_finish;
    end
endmodule : test_s7s_serializer
